// ---- rtl/spd_pkg.sv ----
/*
 * constants, register map and types of the stepper pulse and phase delay block.
 * assumes a 40 MHz system clock shared by every module that imports it.
 */
package spd_pkg;

    localparam int          CLK_HZ          = 40_000_000;
    localparam int          CLK_PER_MHZ     = CLK_HZ / 1_000_000;
    localparam int          SHORT_PULSE_US  = 31_250;
    localparam int          LONG_PULSE_US   = 156_250;
    localparam int          SHORT_PULSE_CYC = SHORT_PULSE_US * CLK_PER_MHZ;
    localparam int          LONG_PULSE_CYC  = LONG_PULSE_US * CLK_PER_MHZ;
    localparam int          MONO_W          = 23;

    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_DELAY_R    = 8'h08;
    localparam logic [7:0]  ADDR_DELAY_S    = 8'h0C;
    localparam logic [7:0]  ADDR_DELAY_T    = 8'h10;

    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_KIND_BIT   = 2;
    localparam int          CTRL_RATIO_LSB  = 4;
    localparam int          CTRL_NEG_LSB    = 8;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK       = 32'h0000_0337;

    localparam int          ST_TOTAL_BIT    = 0;
    localparam int          ST_PHASE_LSB    = 1;
    localparam int          ST_NOLOAD_BIT   = 4;

    localparam logic [1:0]  MODE_STANDALONE = 2'h2;
    localparam logic [1:0]  MODE_LED_DIV    = 2'h3;
    localparam int          STANDALONE_BIT  = 1;

    localparam logic [1:0]  NEG_FERRARIS    = 2'h0;
    localparam logic [1:0]  NEG_ABSOLUTE    = 2'h1;
    localparam logic [1:0]  NEG_PER_PHASE   = 2'h2;
    localparam logic [1:0]  NEG_SIGNED      = 2'h3;

    localparam logic [11:0] DIV_RATIO_0     = 12'h040;
    localparam logic [11:0] DIV_RATIO_1     = 12'h080;
    localparam logic [11:0] DIV_RATIO_2     = 12'h020;
    localparam logic [11:0] DIV_RATIO_3     = 12'h100;
    localparam logic [11:0] DIV_KIND_FACTOR = 12'h00A;

    localparam logic [2:0]  DELAY_PRESCALE  = 3'h7;
    localparam int          TS_W            = 16;
    localparam logic [15:0] TS_ONE          = 16'h0001;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

    typedef enum logic [2:0] {
        SPD_MF_IDLE = 3'b001,
        SPD_MF_A    = 3'b010,
        SPD_MF_B    = 3'b100
    } spd_mono_t;

endpackage

// ---- rtl/spd_if.sv ----
/*
 * carrier between the top module and the phase delay meter.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface spd_if;
    logic       zc_r;
    logic       zc_s;
    logic       zc_t;
    logic [7:0] byte_r;
    logic [7:0] byte_s;
    logic [7:0] byte_t;
    modport meas (input zc_r, input zc_s, input zc_t,
                  output byte_r, output byte_s, output byte_t);
    modport ctl  (output zc_r, output zc_s, output zc_t,
                  input byte_r, input byte_s, input byte_t);
endinterface

// ---- rtl/spd_delay.sv ----
/*
 * phase delay meter: timestamps voltage zero crossings in units of 8 clocks
 * and encodes two delay differences into three bytes.
 * assumes zero crossing strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
module spd_delay
    import spd_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    spd_if.meas       dly
);
    logic [2:0]      pre_reg;
    logic [TS_W-1:0] now_reg;
    logic [TS_W-1:0] ts_r_reg;
    logic [TS_W-1:0] ts_s_reg;
    logic [TS_W-1:0] ts_t_reg;
    logic [2:0]      zc_d_reg;
    logic [23:0]     bytes_reg;

    wire             tick   = (pre_reg == DELAY_PRESCALE);
    wire             rise_r = dly.zc_r & ~zc_d_reg[0];
    wire             rise_s = dly.zc_s & ~zc_d_reg[1];
    wire             rise_t = dly.zc_t & ~zc_d_reg[2];
    wire [TS_W-1:0]  t_rs   = ts_s_reg - ts_r_reg;
    wire [TS_W-1:0]  t_st   = ts_t_reg - ts_s_reg;
    wire [TS_W-1:0]  t_tr   = now_reg - ts_t_reg;
    // value = difference - 1, so time = (mag - 2^11*flag + 1) * 8 clocks
    wire [TS_W-1:0]  asr    = t_st - t_tr - TS_ONE;
    wire [TS_W-1:0]  art    = t_rs - t_st - TS_ONE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_reg   <= 3'h0;
            now_reg   <= '0;
            ts_r_reg  <= '0;
            ts_s_reg  <= '0;
            ts_t_reg  <= '0;
            zc_d_reg  <= 3'h0;
            bytes_reg <= 24'h00_0000;
        end else begin
            pre_reg  <= tick ? 3'h0 : pre_reg + 3'h1;
            now_reg  <= tick ? now_reg + TS_ONE : now_reg;
            zc_d_reg <= {dly.zc_t, dly.zc_s, dly.zc_r};
            if (rise_s)
                ts_s_reg <= now_reg;
            if (rise_t)
                ts_t_reg <= now_reg;
            if (rise_r) begin
                ts_r_reg  <= now_reg;
                bytes_reg <= {asr[11:0], art[11:0]};
            end
        end
    end

    // bytes in t, s, r order
    assign dly.byte_t = bytes_reg[23:16];
    assign dly.byte_s = bytes_reg[15:8];
    assign dly.byte_r = bytes_reg[7:0];
endmodule

// ---- rtl/spd_top.sv ----
/*
 * stepper pulse output stage with negative power handling, pulse pin and
 * phase delay readout over an AHB-Lite slave.
 * assumes energy pulses, phase powers, no-load and zero crossings come from
 * logic on hclk; hready is the bus hready with this slave alone on it.
 */
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps

// Functional notes
// - output mode bit 1 set makes the motor pins drive the stepper directly
// - stepper phases come from energy pulses via divider, mono-flop, decoder
// - kind 0: 31.25 ms pulses at C/64, C/128, C/32, C/256 by ratio
// - kind 1: 156.25 ms pulses at C/640, C/1280, C/320, C/2560
// - decoder alternates divided pulses between phase a and phase b
// - no-load holds both motor pins low and stops integration
// - output mode 2: pulse pin carries energy pulses at rate C
// - output mode 3: pulse pin carries C/64, C/128, C/32, C/256 by ratio
// - negative power mode affects active accumulation only
// - mode 0: signed sum; negative clears flag and holds steppers low
// - mode 1: sum of absolute values; flag reads 1, normal stepping
// - mode 2: per-phase mode; flag reads 1, normal stepping
// - mode 3: signed sum; stepping for negative and positive totals
// - three delay bytes in t, s, r order hold two 12-bit vectors
// - delay = (magnitude - 2^11 flag + 1) times 8 clocks
// - all rates are fractions of the calibrated pulse constant C
module spd_top
    import spd_pkg::*;
#(
    parameter int PW        = 24,
    parameter int SHORT_CYC = SHORT_PULSE_CYC,
    parameter int LONG_CYC  = LONG_PULSE_CYC
)(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          energy_pulse,
    input  wire logic [PW-1:0] power_r,
    input  wire logic [PW-1:0] power_s,
    input  wire logic [PW-1:0] power_t,
    input  wire logic          no_load_flag,
    input  wire logic          zc_r,
    input  wire logic          zc_s,
    input  wire logic          zc_t,
    output logic               motor_pos_pin,
    output logic               motor_neg_pin,
    output logic               pulse_pin,
    output logic               total_dir_flag,
    output logic [2:0]         phase_dir_flag
);
    localparam int TW = PW + 2;

    function automatic logic [11:0] div_of(input logic kind, input logic [1:0] ratio);
        logic [11:0] base;
        base = DIV_RATIO_0;
        unique case (ratio)
            2'h0: base = DIV_RATIO_0;
            2'h1: base = DIV_RATIO_1;
            2'h2: base = DIV_RATIO_2;
            2'h3: base = DIV_RATIO_3;
        endcase
        div_of = kind ? 12'(base * DIV_KIND_FACTOR) : base;
    endfunction

    function automatic logic [TW-1:0] widen(input logic [PW-1:0] p, input logic mag);
        logic [TW-1:0] w;
        w = {{2{p[PW-1]}}, p};
        if (mag && p[PW-1])
            w = -w;
        widen = w;
    endfunction

    function automatic logic [TW-1:0] pos_part(input logic [PW-1:0] p);
        pos_part = p[PW-1] ? '0 : {2'b00, p};
    endfunction

    // bus slave
    logic [31:0]       ctrl_reg;
    logic [31:0]       hrdata_reg;
    logic              hreadyout_reg;
    logic              wr_pend_reg;
    logic [7:0]        wr_addr_reg;

    wire               addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire [7:0]         a_off      = haddr[7:0];
    wire               a_hit      = (haddr[31:8] == 24'h00_0000);
    wire [1:0]         output_mode_sel = ctrl_reg[CTRL_MODE_LSB +: 2];
    wire               energy_kind_sel = ctrl_reg[CTRL_KIND_BIT];
    wire [1:0]         motor_ratio_sel = ctrl_reg[CTRL_RATIO_LSB +: 2];
    wire [1:0]         neg_power_mode  = ctrl_reg[CTRL_NEG_LSB +: 2];
    wire [31:0]        status_word;
    wire [31:0]        rd_mux;

    spd_if u_if ();
    assign u_if.zc_r = zc_r;
    assign u_if.zc_s = zc_s;
    assign u_if.zc_t = zc_t;

    spd_delay u_delay (
        .hclk    (hclk),
        .hresetn (hresetn),
        .dly     (u_if.meas)
    );

    assign status_word = {27'h0, no_load_flag, phase_dir_flag, total_dir_flag};
    assign rd_mux = !a_hit                   ? 32'h0000_0000 :
                    (a_off == ADDR_CTRL)     ? ctrl_reg :
                    (a_off == ADDR_STATUS)   ? status_word :
                    (a_off == ADDR_DELAY_R)  ? {24'h00_0000, u_if.byte_r} :
                    (a_off == ADDR_DELAY_S)  ? {24'h00_0000, u_if.byte_s} :
                    (a_off == ADDR_DELAY_T)  ? {24'h00_0000, u_if.byte_t} :
                                               32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg      <= CTRL_RESET;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
        end else begin
            hreadyout_reg <= 1'b1;
            wr_pend_reg   <= addr_phase & hwrite & a_hit;
            wr_addr_reg   <= a_off;
            if (addr_phase && !hwrite)
                hrdata_reg <= rd_mux;
            if (wr_pend_reg && wr_addr_reg == ADDR_CTRL)
                ctrl_reg <= hwdata & CTRL_MASK;
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = 1'b0;

    // power direction and accumulated total
    logic [TW-1:0]     total;
    logic              step_ok;
    logic              flag_next;
    wire  [TW-1:0]     sum_signed = widen(power_r, 1'b0) + widen(power_s, 1'b0)
                                    + widen(power_t, 1'b0);
    wire  [TW-1:0]     sum_abs    = widen(power_r, 1'b1) + widen(power_s, 1'b1)
                                    + widen(power_t, 1'b1);
    wire  [TW-1:0]     sum_pos    = pos_part(power_r) + pos_part(power_s)
                                    + pos_part(power_t);

    // only active pulse stepping is gated here; reactive paths are elsewhere
    always_comb begin
        total     = sum_signed;
        step_ok   = 1'b1;
        flag_next = 1'b1;
        unique case (neg_power_mode)
            NEG_FERRARIS: begin
                total     = sum_signed;
                flag_next = ~sum_signed[TW-1];
                step_ok   = ~sum_signed[TW-1];
            end
            NEG_ABSOLUTE: begin
                total     = sum_abs;
            end
            NEG_PER_PHASE: begin
                total     = sum_pos;
            end
            NEG_SIGNED: begin
                total     = sum_signed;
                flag_next = ~sum_signed[TW-1];
            end
        endcase
    end

    logic [TW-1:0]     total_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            total_dir_flag <= 1'b1;
            phase_dir_flag <= 3'h7;
            total_reg      <= '0;
        end else begin
            total_dir_flag <= flag_next;
            phase_dir_flag <= ~{power_t[PW-1], power_s[PW-1], power_r[PW-1]};
            total_reg      <= total;
        end
    end

    // energy pulse at rate C qualified by load and sign
    wire               motor_en   = output_mode_sel[STANDALONE_BIT];
    wire               pulse_ok   = energy_pulse & ~no_load_flag;
    wire               motor_in   = pulse_ok & step_ok;
    wire  [11:0]       motor_div  = div_of(energy_kind_sel, motor_ratio_sel);
    wire  [11:0]       led_div    = div_of(1'b0, motor_ratio_sel);

    logic [11:0]       mdiv_cnt_reg;
    logic [11:0]       ldiv_cnt_reg;
    wire               mdiv_wrap  = motor_in & (mdiv_cnt_reg >= motor_div - 12'h001);
    wire               ldiv_wrap  = pulse_ok & (ldiv_cnt_reg >= led_div - 12'h001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdiv_cnt_reg <= 12'h000;
            ldiv_cnt_reg <= 12'h000;
        end else begin
            if (motor_in)
                mdiv_cnt_reg <= mdiv_wrap ? 12'h000 : mdiv_cnt_reg + 12'h001;
            if (pulse_ok)
                ldiv_cnt_reg <= ldiv_wrap ? 12'h000 : ldiv_cnt_reg + 12'h001;
        end
    end

    // mono-flop and alternating decoder
    spd_mono_t         mono_reg;
    spd_mono_t         mono_next;
    logic [MONO_W-1:0] mono_cnt_reg;
    logic              next_b_reg;
    logic              pend_reg;
    wire  [MONO_W-1:0] pulse_len  = energy_kind_sel ? MONO_W'(LONG_CYC - 1)
                                                    : MONO_W'(SHORT_CYC - 1);
    wire               mono_done  = (mono_cnt_reg >= pulse_len);
    wire               start      = (mdiv_wrap | pend_reg) & (mono_reg == SPD_MF_IDLE);

    always_comb begin
        mono_next = mono_reg;
        unique case (mono_reg)
            SPD_MF_IDLE: begin
                if (start)
                    mono_next = next_b_reg ? SPD_MF_B : SPD_MF_A;
            end
            SPD_MF_A: begin
                if (mono_done || no_load_flag)
                    mono_next = SPD_MF_IDLE;
            end
            SPD_MF_B: begin
                if (mono_done || no_load_flag)
                    mono_next = SPD_MF_IDLE;
            end
            default: mono_next = SPD_MF_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mono_reg     <= SPD_MF_IDLE;
            mono_cnt_reg <= '0;
            next_b_reg   <= 1'b0;
            pend_reg     <= 1'b0;
        end else begin
            mono_reg     <= mono_next;
            mono_cnt_reg <= (mono_reg == SPD_MF_IDLE) ? '0 : mono_cnt_reg + MONO_W'(1);
            if (start)
                next_b_reg <= ~next_b_reg;
            if (no_load_flag)
                pend_reg <= 1'b0;
            else if (mdiv_wrap && mono_reg != SPD_MF_IDLE)
                pend_reg <= 1'b1;
            else if (start)
                pend_reg <= 1'b0;
        end
    end

    // pins: active high pulses, idle low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motor_pos_pin <= 1'b0;
            motor_neg_pin <= 1'b0;
            pulse_pin     <= 1'b0;
        end else begin
            motor_pos_pin <= motor_en & ~no_load_flag & (mono_next == SPD_MF_A);
            motor_neg_pin <= motor_en & ~no_load_flag & (mono_next == SPD_MF_B);
            if (output_mode_sel == MODE_LED_DIV)
                pulse_pin <= ldiv_wrap;
            else
                pulse_pin <= pulse_ok;
        end
    end

    wire unused_ok = &{1'b0, hsize, total_reg};
endmodule

// ---- bench/spd_motor_model.sv ----
/*
 * stepper motor counter and pulse led seen from the motor and pulse pins.
 * assumes pins are registered on hclk; clr restarts every count.
 */
`timescale 1ns/1ps
module spd_motor_model
    import spd_pkg::*;
(
    input  wire logic hclk,
    input  wire logic clr,
    input  wire logic motor_pos_pin,
    input  wire logic motor_neg_pin,
    input  wire logic pulse_pin,
    output int        pos_cnt,
    output int        neg_cnt,
    output int        led_cnt,
    output int        width
);
    logic pos_q;
    logic neg_q;
    int   w;
    // coil steps on a rising level, led counts lit cycles
    always @(posedge hclk) begin
        pos_q <= motor_pos_pin;
        neg_q <= motor_neg_pin;
        if (clr) begin
            pos_cnt <= 0;
            neg_cnt <= 0;
            led_cnt <= 0;
            width   <= 0;
            w       <= 0;
        end else begin
            pos_cnt <= pos_cnt + int'(motor_pos_pin && !pos_q);
            neg_cnt <= neg_cnt + int'(motor_neg_pin && !neg_q);
            led_cnt <= led_cnt + int'(pulse_pin);
            if (motor_pos_pin || motor_neg_pin) begin
                w <= w + 1;
            end else if (w != 0) begin
                width <= w;
                w     <= 0;
            end
        end
    end
endmodule

// ---- bench/spd_top_asserts.sv ----
/*
 * port checker for the stepper pulse stage.
 * assumes one hclk domain and hresetn as its asynchronous reset.
 */
`timescale 1ns/1ps
module spd_top_asserts
    import spd_pkg::*;
#(
    parameter int PW        = 24,
    parameter int SHORT_CYC = 20,
    parameter int LONG_CYC  = 50
)(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          energy_pulse,
    input wire logic [PW-1:0] power_r,
    input wire logic [PW-1:0] power_s,
    input wire logic [PW-1:0] power_t,
    input wire logic          no_load_flag,
    input wire logic          motor_pos_pin,
    input wire logic          motor_neg_pin,
    input wire logic          pulse_pin,
    input wire logic [2:0]    phase_dir_flag
);
    logic [31:0] pos_w;
    logic [31:0] neg_w;
    logic        last_pos;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_w    <= 32'h0;
            neg_w    <= 32'h0;
            last_pos <= 1'b0;
        end else begin
            pos_w <= motor_pos_pin ? pos_w + 32'h1 : 32'h0;
            neg_w <= motor_neg_pin ? neg_w + 32'h1 : 32'h0;
            if ($rose(motor_pos_pin)) begin
                last_pos <= 1'b1;
            end else if ($rose(motor_neg_pin)) begin
                last_pos <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_noload_held;
        no_load_flag ##1 no_load_flag;
    endsequence
    property p_noload_low;
        s_noload_held |-> !motor_pos_pin && !motor_neg_pin;
    endproperty
    property p_not_both;
        !(motor_pos_pin && motor_neg_pin);
    endproperty
    property p_pos_width;
        $fell(motor_pos_pin) && !$past(no_load_flag) |-> pos_w == SHORT_CYC || pos_w == LONG_CYC;
    endproperty
    property p_neg_width;
        $fell(motor_neg_pin) && !$past(no_load_flag) |-> neg_w == SHORT_CYC || neg_w == LONG_CYC;
    endproperty
    property p_led_cause;
        pulse_pin |-> $past(energy_pulse) && !$past(no_load_flag);
    endproperty
    property p_dir_phase;
        $past(hresetn) |-> phase_dir_flag ==
            {~$past(power_t[PW-1]), ~$past(power_s[PW-1]), ~$past(power_r[PW-1])};
    endproperty
    property p_alt_pos;
        $rose(motor_pos_pin) |-> !last_pos;
    endproperty
    property p_alt_neg;
        $rose(motor_neg_pin) |-> last_pos;
    endproperty
    a_noload_low: assert property (p_noload_low) else $error("motor pin high in no load");
    a_not_both: assert property (p_not_both) else $error("both motor pins high");
    a_pos_width: assert property (p_pos_width) else $error("pos pulse width wrong");
    a_neg_width: assert property (p_neg_width) else $error("neg pulse width wrong");
    a_led_cause: assert property (p_led_cause) else $error("pulse pin without energy");
    a_dir_phase: assert property (p_dir_phase) else $error("phase flags wrong");
    a_alt_pos: assert property (p_alt_pos) else $error("pos stepped twice");
    a_alt_neg: assert property (p_alt_neg) else $error("neg stepped out of turn");
endmodule

bind spd_top spd_top_asserts #(.PW(PW), .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC))
    i_spd_top_asserts (.hclk(hclk), .hresetn(hresetn), .energy_pulse(energy_pulse),
    .power_r(power_r), .power_s(power_s), .power_t(power_t), .no_load_flag(no_load_flag),
    .motor_pos_pin(motor_pos_pin), .motor_neg_pin(motor_neg_pin), .pulse_pin(pulse_pin),
    .phase_dir_flag(phase_dir_flag));

// ---- bench/spd_top_tb_top.sv ----
/*
 * self-checking bench of spd_top with short mono-flop counts.
 * assumes spd_motor_model on the pins and the bound port checker.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        bad_count++; \
        $display("unexpected at %0t: got %0h want %0h", $time, (a), (e)); \
    end \
end
module spd_top_tb_top;
    import spd_pkg::*;
    localparam int SC = 20;
    localparam int LC = 50;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, energy_pulse, no_load_flag;
    logic        zc_r, zc_s, zc_t, motor_pos_pin, motor_neg_pin, pulse_pin, total_dir_flag;
    logic        clr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, phase_dir_flag;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [23:0] power_r, power_s, power_t, vec;
    int          bad_count, check_count, pos_cnt, neg_cnt, led_cnt, width, a, b, c;
    int          ratio_tab [4] = '{64, 128, 32, 256};
    spd_top #(.PW(24), .SHORT_CYC(SC), .LONG_CYC(LC)) i_spd_top (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .energy_pulse(energy_pulse), .power_r(power_r), .power_s(power_s),
        .power_t(power_t), .no_load_flag(no_load_flag), .zc_r(zc_r), .zc_s(zc_s), .zc_t(zc_t),
        .motor_pos_pin(motor_pos_pin), .motor_neg_pin(motor_neg_pin), .pulse_pin(pulse_pin),
        .total_dir_flag(total_dir_flag), .phase_dir_flag(phase_dir_flag));
    spd_motor_model i_spd_motor_model (.hclk(hclk), .clr(clr), .motor_pos_pin(motor_pos_pin),
        .motor_neg_pin(motor_neg_pin), .pulse_pin(pulse_pin), .pos_cnt(pos_cnt),
        .neg_cnt(neg_cnt), .led_cnt(led_cnt), .width(width));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic edge_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ad};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        edge_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        `CHK(rd, e)
    endtask
    // one configuration, 2N energy pulses, then the counts of the far side
    task automatic run_case(input int md, input int kd, input int rt, input int ng,
                            input logic nl, input logic np);
        int          n, base, acc;
        logic [23:0] p;
        logic        fl;
        base = ratio_tab[rt];
        n = base * (kd ? 10 : 1);
        acc = int'(!nl && !(np && ng == 0));
        fl = (ng == 1 || ng == 2) ? 1'b1 : ~np;
        p = 24'($urandom_range(5000, 4));
        power_r <= np ? -p : p;
        power_s <= np ? -(p >> 1) : p >> 1;
        power_t <= np ? -(p >> 2) : p + 24'h1;
        no_load_flag <= nl;
        bus(1'b1, ADDR_CTRL, 32'(md) | (32'(kd) << CTRL_KIND_BIT) | (32'(rt) << CTRL_RATIO_LSB)
            | (32'(ng) << CTRL_NEG_LSB));
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        energy_pulse <= 1'b1;
        repeat (2 * n) @(posedge hclk);
        energy_pulse <= 1'b0;
        repeat (LC + 5) @(posedge hclk);
        `CHK(pos_cnt, acc * int'(md >= 2))
        `CHK(neg_cnt, acc * int'(md >= 2))
        `CHK(led_cnt, int'(!nl) * (md == 3 ? 2 * n / base : 2 * n))
        if (acc != 0 && md >= 2)
            `CHK(width, kd ? LC : SC)
        `CHK(total_dir_flag, fl)
        rd_chk(ADDR_STATUS, {27'h0, nl, {3{~np}}, fl});
    endtask
    task automatic zc_pulse(input int ph, input int gap);
        {zc_t, zc_s, zc_r} <= 3'(1 << ph);
        @(posedge hclk);
        {zc_t, zc_s, zc_r} <= 3'h0;
        repeat (8 * gap - 1) @(posedge hclk);
    endtask
    initial begin
        {hresetn, hsel, hwrite, energy_pulse, no_load_flag, zc_r, zc_s, zc_t, clr} = '0;
        {htrans, haddr, hwdata, power_r, power_s, power_t} = '0;
        hsize = 3'h2;
        bad_count = 0;
        check_count = 0;
        void'($urandom(32'hF9278BB7));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(ADDR_CTRL, CTRL_RESET);
        bus(1'b1, ADDR_CTRL, 32'hFFFFFFFF);
        rd_chk(ADDR_CTRL, CTRL_MASK);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rd_chk(8'h40, 32'h0);
        for (int k = 0; k < 8; k++)
            run_case((k[2] ^ k[0]) ? 3 : 2, k / 4, k % 4, 0, 1'b0, 1'b0);
        run_case(0, 0, 2, 0, 1'b0, 1'b0);
        run_case(2, 0, 2, 0, 1'b1, 1'b0);
        for (int m = 0; m < 4; m++)
            run_case(2, 0, 2, m, 1'b0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            a = $urandom_range(200, 20);
            b = $urandom_range(200, 20);
            c = $urandom_range(200, 20);
            zc_pulse(0, a);
            zc_pulse(1, b);
            zc_pulse(2, c);
            zc_pulse(0, 1);
            vec = {12'(b - c - 1), 12'(a - b - 1)};
            rd_chk(ADDR_DELAY_R, {24'h0, vec[7:0]});
            rd_chk(ADDR_DELAY_S, {24'h0, vec[15:8]});
            rd_chk(ADDR_DELAY_T, {24'h0, vec[23:16]});
        end
        final_report();
    end
endmodule
